// ---- posdone_pkg.sv ----
// Purpose: constants for the positioning done detector
// Assumes: 16-bit register port, 100 MHz mclk, 1 ms tick input
// Notes:   register indices are word offsets on the plain port
package posdone_pkg;
   localparam int          AW            = 4;
   localparam int          DW            = 16;
   localparam logic [3:0]  A_CMP_SEL     = 4'h0;
   localparam logic [3:0]  A_CMP_THR     = 4'h1;
   localparam logic [3:0]  A_CLS_SEL     = 4'h2;
   localparam logic [3:0]  A_CLS_THR     = 4'h3;
   localparam logic [3:0]  A_HOLD        = 4'h4;
   localparam logic [3:0]  A_CTRL        = 4'h5;
   localparam logic [3:0]  A_STATUS      = 4'h6;
   localparam logic [3:0]  A_IRQ_STAT    = 4'h7;
   localparam logic [3:0]  A_IRQ_EN      = 4'h8;
   localparam logic [3:0]  A_IRQ_CLR     = 4'h9;
   localparam logic [1:0]  SEL_RST       = 2'h0;
   localparam logic [14:0] CMP_THR_RST   = 15'h000a;
   localparam logic [14:0] CLS_THR_RST   = 15'h0064;
   localparam logic [14:0] HOLD_RST      = 15'h000a;
   localparam logic [1:0]  SEL_ERR_ONLY  = 2'h0;
   localparam logic [1:0]  SEL_RAW_ZERO  = 2'h1;
   localparam logic [1:0]  SEL_FILT_ZERO = 2'h2;
   localparam logic [1:0]  SEL_LATCH     = 2'h3;
   // irq / control bit positions
   localparam int          B_CMP_RISE    = 0;
   localparam int          B_CMP_FALL    = 1;
   localparam int          B_CLS_RISE    = 2;
   localparam int          B_CLS_FALL    = 3;
   localparam int          NIRQ          = 4;
   localparam int          B_POS_MODE    = 0;
   localparam int          B_RUNNING     = 1;
endpackage

// ---- positioning_done_detector.sv ----
// Purpose: completion and close flags from position error, speed and hold time
// Assumes: error and speed inputs come from logic on mclk; ms tick is one-cycle pulse
// Notes:   mode/run come from control register bits; flag and read data outputs are registered, irq is gated from registers
//
// Design decisions made here: the register offsets and the strobed register port.
`timescale 1ns/10ps
// Overview of operation
// - completion selector 0..3, reset 0, acts at once when written
// - completion flag needs error within threshold for whole hold time
// - selector 0: error below threshold only, else flag cleared
// - selector 1: also raw speed command zero, else cleared
// - selector 2: also filtered speed command zero, else cleared
// - selector 3: set on error and zero speed, clear only on nonzero speed
// - completion threshold 0..32767, reset 10, immediate
// - flags valid only in position mode while running
// - close flag needs error within close threshold for hold time
// - close selector 0..3, reset 0, immediate
// - close selector has same four conditions on close threshold
// - close threshold 0..32767, reset 100
// - shared hold time in ms, 0..32767, reset 10
module positioning_done_detector
   import posdone_pkg::*;
#(
   parameter int EW = 32
) (
   input  wire logic                    mclk,
   input  wire logic                    rst_n,
   input  wire logic                    ms_tick,
   input  wire logic signed [EW-1:0]    following_error,
   input  wire logic signed [15:0]      raw_speed_command,
   input  wire logic signed [15:0]      filtered_speed_command,
   input  wire logic [posdone_pkg::AW-1:0] addr,
   input  wire logic [posdone_pkg::DW-1:0] wdata,
   input  wire logic                    wr,
   input  wire logic                    rd,
   output logic [posdone_pkg::DW-1:0]   rdata,
   output logic                         completion_flag_output,
   output logic                         close_flag_output,
   output logic                         irq
);
   import posdone_pkg::*;

   // error and threshold compares assume this range
   if (EW < 16 || EW > 32) begin : g_bad_ew
      $error("EW must be 16..32");
   end

   // magnitude read as unsigned, so the most negative error keeps its true size
   function automatic logic [EW-1:0] abs_err(input logic signed [EW-1:0] e);
      abs_err = e[EW-1] ? EW'(-e) : EW'(e);
   endfunction

   // one compare function used by both flags, each with its own threshold
   function automatic logic below_thr(input logic [EW-1:0] a, input logic [14:0] t);
      below_thr = a < EW'(t);
   endfunction

   function automatic logic qualify(input logic [1:0] sel, input logic below,
                                    input logic raw_z, input logic filt_z);
      case (sel)
         SEL_ERR_ONLY:  qualify = below;
         SEL_RAW_ZERO:  qualify = below && raw_z;
         SEL_FILT_ZERO: qualify = below && filt_z;
         default:       qualify = below && raw_z;
      endcase
   endfunction

   // registers
   logic [1:0]      cmp_sel_r, cmp_sel_nxt, cls_sel_r, cls_sel_nxt;
   logic [14:0]     cmp_thr_r, cmp_thr_nxt, cls_thr_r, cls_thr_nxt;
   logic [14:0]     hold_r, hold_nxt;
   logic [1:0]      ctrl_r, ctrl_nxt;
   logic [NIRQ-1:0] ists_r, ists_nxt, ien_r, ien_nxt;
   logic [DW-1:0]   rdata_nxt;

   // write decode; status and irq status are read-only, writes there are dropped
   always_comb begin
      cmp_sel_nxt = cmp_sel_r;
      cls_sel_nxt = cls_sel_r;
      cmp_thr_nxt = cmp_thr_r;
      cls_thr_nxt = cls_thr_r;
      hold_nxt    = hold_r;
      ctrl_nxt    = ctrl_r;
      ien_nxt     = ien_r;
      if (wr) begin
         if (addr == A_CMP_SEL) begin
            cmp_sel_nxt = wdata[1:0];
         end else if (addr == A_CMP_THR) begin
            cmp_thr_nxt = wdata[14:0];
         end else if (addr == A_CLS_SEL) begin
            cls_sel_nxt = wdata[1:0];
         end else if (addr == A_CLS_THR) begin
            cls_thr_nxt = wdata[14:0];
         end else if (addr == A_HOLD) begin
            hold_nxt = wdata[14:0];
         end else if (addr == A_CTRL) begin
            ctrl_nxt = wdata[1:0];
         end else if (addr == A_IRQ_EN) begin
            ien_nxt = wdata[NIRQ-1:0];
         end
      end
   end

   // flag datapath
   logic [EW-1:0]   aerr;
   logic            raw_z, filt_z, active;
   logic            cmp_q, cls_q;
   logic [14:0]     cmp_cnt_r, cmp_cnt_nxt, cls_cnt_r, cls_cnt_nxt;
   logic            cmp_f_r, cmp_f_nxt, cls_f_r, cls_f_nxt;

   assign aerr   = abs_err(following_error);
   assign raw_z  = raw_speed_command == 16'sh0000;
   assign filt_z = filtered_speed_command == 16'sh0000;
   assign active = ctrl_r[B_POS_MODE] && ctrl_r[B_RUNNING];
   // selector 3 qualifies on raw speed; its latch lives in settle_step
   assign cmp_q  = qualify(cmp_sel_r, below_thr(aerr, cmp_thr_r), raw_z, filt_z);
   assign cls_q  = qualify(cls_sel_r, below_thr(aerr, cls_thr_r), raw_z, filt_z);

   // hold counter plus flag update for one flag; returns {flag, count}
   function automatic logic [15:0] settle_step(input logic [1:0] sel, input logic q,
                                               input logic [14:0] cnt, input logic f,
                                               input logic act, input logic rz,
                                               input logic [14:0] hold, input logic tick);
      logic [14:0] cnt_o;
      logic        f_o;
      cnt_o = cnt;
      f_o   = f;
      if (!act) begin
         cnt_o = '0;
         f_o   = 1'b0;
      end else if (!q) begin
         // any lapse starts the hold interval over
         cnt_o = '0;
         if (sel != SEL_LATCH || !rz) begin
            f_o = 1'b0;
         end
      end else if (cnt >= hold) begin
         f_o = 1'b1;
      end else if (tick) begin
         // stops at hold, so the count cannot wrap while a flag stays up
         cnt_o = cnt + 15'h0001;
      end
      settle_step = {f_o, cnt_o};
   endfunction

   always_comb begin
      {cmp_f_nxt, cmp_cnt_nxt} = settle_step(cmp_sel_r, cmp_q, cmp_cnt_r, cmp_f_r, active,
                                             raw_z, hold_r, ms_tick);
      {cls_f_nxt, cls_cnt_nxt} = settle_step(cls_sel_r, cls_q, cls_cnt_r, cls_f_r, active,
                                             raw_z, hold_r, ms_tick);
   end

   // interrupts: edges of each flag; set wins over clear
   logic [NIRQ-1:0] ev;
   always_comb begin
      ev = '0;
      ev[B_CMP_RISE] = cmp_f_nxt && !cmp_f_r;
      ev[B_CMP_FALL] = !cmp_f_nxt && cmp_f_r;
      ev[B_CLS_RISE] = cls_f_nxt && !cls_f_r;
      ev[B_CLS_FALL] = !cls_f_nxt && cls_f_r;
      ists_nxt = ists_r;
      if (wr && addr == A_IRQ_CLR) begin
         ists_nxt = ists_r & ~wdata[NIRQ-1:0];
      end
      ists_nxt = ists_nxt | ev;
   end

   // unmapped and write-only indices read as zero
   always_comb begin
      rdata_nxt = '0;
      if (rd) begin
         if (addr == A_CMP_SEL) begin
            rdata_nxt = {14'h0000, cmp_sel_r};
         end else if (addr == A_CMP_THR) begin
            rdata_nxt = {1'b0, cmp_thr_r};
         end else if (addr == A_CLS_SEL) begin
            rdata_nxt = {14'h0000, cls_sel_r};
         end else if (addr == A_CLS_THR) begin
            rdata_nxt = {1'b0, cls_thr_r};
         end else if (addr == A_HOLD) begin
            rdata_nxt = {1'b0, hold_r};
         end else if (addr == A_CTRL) begin
            rdata_nxt = {14'h0000, ctrl_r};
         end else if (addr == A_STATUS) begin
            rdata_nxt = {14'h0000, cls_f_r, cmp_f_r};
         end else if (addr == A_IRQ_STAT) begin
            rdata_nxt = {12'h000, ists_r};
         end else if (addr == A_IRQ_EN) begin
            rdata_nxt = {12'h000, ien_r};
         end
      end
   end

   // configuration group
   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         cmp_sel_r <= SEL_RST;
         cls_sel_r <= SEL_RST;
         cmp_thr_r <= CMP_THR_RST;
         cls_thr_r <= CLS_THR_RST;
         hold_r    <= HOLD_RST;
         ctrl_r    <= '0;
         ien_r     <= '0;
      end else begin
         cmp_sel_r <= cmp_sel_nxt;
         cls_sel_r <= cls_sel_nxt;
         cmp_thr_r <= cmp_thr_nxt;
         cls_thr_r <= cls_thr_nxt;
         hold_r    <= hold_nxt;
         ctrl_r    <= ctrl_nxt;
         ien_r     <= ien_nxt;
      end
   end

   // hold counters and flags
   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         cmp_cnt_r <= '0;
         cls_cnt_r <= '0;
         cmp_f_r   <= 1'b0;
         cls_f_r   <= 1'b0;
      end else begin
         cmp_cnt_r <= cmp_cnt_nxt;
         cls_cnt_r <= cls_cnt_nxt;
         cmp_f_r   <= cmp_f_nxt;
         cls_f_r   <= cls_f_nxt;
      end
   end

   // sticky interrupt status
   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         ists_r <= '0;
      end else begin
         ists_r <= ists_nxt;
      end
   end

   // read data stands one cycle, then returns to zero
   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         rdata <= '0;
      end else begin
         rdata <= rdata_nxt;
      end
   end

   assign completion_flag_output = cmp_f_r;
   assign close_flag_output      = cls_f_r;
   // level output: stays up until software clears or masks the cause
   assign irq                    = |(ists_r & ien_r);

   // checks
   inactive_clears_a: assert property (@(posedge mclk) disable iff (!rst_n)
      !active |=> !cmp_f_r && !cls_f_r && cmp_cnt_r == '0 && cls_cnt_r == '0)
      else $error("flags not cleared when inactive");
   valid_only_a: assert property (@(posedge mclk) disable iff (!rst_n)
      $rose(cmp_f_r) |-> $past(active))
      else $error("completion flag rose while inactive");
   hold_met_a: assert property (@(posedge mclk) disable iff (!rst_n)
      $rose(cmp_f_r) |-> $past(cmp_cnt_r) >= $past(hold_r) && $past(cmp_q))
      else $error("completion flag before hold time");
   close_hold_a: assert property (@(posedge mclk) disable iff (!rst_n)
      $rose(cls_f_r) |-> $past(cls_cnt_r) >= $past(hold_r) && $past(cls_q))
      else $error("close flag before hold time");
   restart_cnt_a: assert property (@(posedge mclk) disable iff (!rst_n)
      !cmp_q |=> cmp_cnt_r == '0)
      else $error("hold counter not restarted");
   sel0_clear_a: assert property (@(posedge mclk) disable iff (!rst_n)
      cmp_sel_r == SEL_ERR_ONLY && !below_thr(aerr, cmp_thr_r) |=> !cmp_f_r)
      else $error("selector 0 flag not cleared");
   sel1_speed_a: assert property (@(posedge mclk) disable iff (!rst_n)
      cmp_sel_r == SEL_RAW_ZERO && !raw_z |=> !cmp_f_r)
      else $error("selector 1 flag with speed");
   sel2_filt_a: assert property (@(posedge mclk) disable iff (!rst_n)
      cmp_sel_r == SEL_FILT_ZERO && !filt_z |=> !cmp_f_r)
      else $error("selector 2 flag with filtered speed");
   sel3_latch_a: assert property (@(posedge mclk) disable iff (!rst_n)
      cmp_sel_r == SEL_LATCH && cmp_sel_nxt == SEL_LATCH && cmp_f_r && active && raw_z
      |=> cmp_f_r)
      else $error("selector 3 flag dropped at zero speed");
   cfg_write_a: assert property (@(posedge mclk) disable iff (!rst_n)
      wr && addr == A_CMP_THR |=> cmp_thr_r == $past(wdata[14:0]))
      else $error("threshold write not immediate");
   close_sel_a: assert property (@(posedge mclk) disable iff (!rst_n)
      wr && addr == A_CLS_SEL |=> cls_sel_r == $past(wdata[1:0]))
      else $error("close selector write lost");
   hold_write_a: assert property (@(posedge mclk) disable iff (!rst_n)
      wr && addr == A_HOLD |=> hold_r == $past(wdata[14:0]))
      else $error("hold time write lost");
   cmp_count_a: assert property (@(posedge mclk) disable iff (!rst_n)
      active && cmp_q && ms_tick && cmp_cnt_r < hold_r |=> cmp_cnt_r == $past(cmp_cnt_r) + 15'h0001)
      else $error("completion hold count missed a tick");
   zero_hold_a: assert property (@(posedge mclk) disable iff (!rst_n)
      active && cmp_q && hold_r == '0 |=> cmp_f_r)
      else $error("completion flag late with zero hold");

   // close flag checks
   cls_sel0_a: assert property (@(posedge mclk) disable iff (!rst_n)
      cls_sel_r == SEL_ERR_ONLY && !below_thr(aerr, cls_thr_r) |=> !cls_f_r)
      else $error("close selector 0 flag not cleared");
   cls_sel1_a: assert property (@(posedge mclk) disable iff (!rst_n)
      cls_sel_r == SEL_RAW_ZERO && !raw_z |=> !cls_f_r)
      else $error("close selector 1 flag with speed");
   cls_sel2_a: assert property (@(posedge mclk) disable iff (!rst_n)
      cls_sel_r == SEL_FILT_ZERO && !filt_z |=> !cls_f_r)
      else $error("close selector 2 flag with filtered speed");
   cls_latch_a: assert property (@(posedge mclk) disable iff (!rst_n)
      cls_sel_r == SEL_LATCH && cls_f_r && active && raw_z |=> cls_f_r)
      else $error("close selector 3 flag dropped at zero speed");
   cls_restart_a: assert property (@(posedge mclk) disable iff (!rst_n)
      !cls_q |=> cls_cnt_r == '0)
      else $error("close hold counter not restarted");
   cls_valid_a: assert property (@(posedge mclk) disable iff (!rst_n)
      $rose(cls_f_r) |-> $past(active))
      else $error("close flag rose while inactive");
   cls_count_a: assert property (@(posedge mclk) disable iff (!rst_n)
      active && cls_q && ms_tick && cls_cnt_r < hold_r |=> cls_cnt_r == $past(cls_cnt_r) + 15'h0001)
      else $error("close hold count missed a tick");
   cls_zero_hold_a: assert property (@(posedge mclk) disable iff (!rst_n)
      active && cls_q && hold_r == '0 |=> cls_f_r)
      else $error("close flag late with zero hold");

   // register port and interrupt checks
   sel_write_a: assert property (@(posedge mclk) disable iff (!rst_n)
      wr && addr == A_CMP_SEL |=> cmp_sel_r == $past(wdata[1:0]))
      else $error("completion selector write lost");
   cls_thr_write_a: assert property (@(posedge mclk) disable iff (!rst_n)
      wr && addr == A_CLS_THR |=> cls_thr_r == $past(wdata[14:0]))
      else $error("close threshold write lost");
   ctrl_write_a: assert property (@(posedge mclk) disable iff (!rst_n)
      wr && addr == A_CTRL |=> ctrl_r == $past(wdata[1:0]))
      else $error("mode and run write lost");
   rdata_idle_a: assert property (@(posedge mclk) disable iff (!rst_n)
      !rd |=> rdata == '0)
      else $error("read data not zero after idle cycle");
   status_read_a: assert property (@(posedge mclk) disable iff (!rst_n)
      rd && addr == A_STATUS |=> rdata == {14'h0000, $past(cls_f_r), $past(cmp_f_r)})
      else $error("status read does not show flags");
   irq_set_wins_a: assert property (@(posedge mclk) disable iff (!rst_n)
      |ev |=> (ists_r & $past(ev)) == $past(ev))
      else $error("interrupt event not latched");
   irq_clear_a: assert property (@(posedge mclk) disable iff (!rst_n)
      wr && addr == A_IRQ_CLR && ev == '0 |=> (ists_r & $past(wdata[NIRQ-1:0])) == '0)
      else $error("interrupt clear not applied");
endmodule

// ---- host_flag_monitor.sv ----
// Purpose: host side model that watches the completion flag
// Assumes: flag is a registered level on mclk
// Notes:   the host only observes; it never drives the block
`timescale 1ns/10ps
module host_flag_monitor (
   input  wire logic       mclk,
   input  wire logic       rst_n,
   input  wire logic       flag,
   output logic [7:0]      rises
);
   logic flag_r;
   // counts distinct assertions, so a flag that chatters shows up as extra rises
   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         flag_r <= 1'b0;
         rises  <= 8'h00;
      end else begin
         flag_r <= flag;
         if (flag && !flag_r) begin
            rises <= rises + 8'h01;
         end
      end
   end
endmodule

// ---- positioning_done_detector_tb.sv ----
// Purpose: self-checking bench for the positioning done detector
// Assumes: ms tick driven by hand, hold programmed as two ticks
// Notes:   flags are sampled three cycles after each input step
`timescale 1ns/10ps
module positioning_done_detector_tb;
   import posdone_pkg::*;
   logic               mclk = 1'b0;
   logic               rst_n = 1'b0;
   logic               ms_tick = 1'b0;
   logic signed [31:0] following_error = 32'sh0;
   logic signed [15:0] raw_speed_command = 16'sh0;
   logic signed [15:0] filtered_speed_command = 16'sh0;
   logic [AW-1:0]      addr = 4'h0;
   logic [DW-1:0]      wdata = 16'h0000;
   logic               wr = 1'b0;
   logic               rd = 1'b0;
   logic [DW-1:0]      rdata;
   logic               completion_flag_output;
   logic               close_flag_output;
   logic               irq;
   logic [7:0]         rises;
   logic [DW-1:0]      v;
   logic [DW-1:0]      rst_tab [5] = '{16'h0000, 16'h000a, 16'h0000, 16'h0064, 16'h000a};
   int                 mismatches = 0;
   int                 cmp_count = 0;

   always #5 mclk = ~mclk;

   positioning_done_detector #(.EW(32)) dut (.mclk(mclk), .rst_n(rst_n), .ms_tick(ms_tick),
      .following_error(following_error), .raw_speed_command(raw_speed_command),
      .filtered_speed_command(filtered_speed_command), .addr(addr), .wdata(wdata),
      .wr(wr), .rd(rd), .rdata(rdata), .completion_flag_output(completion_flag_output),
      .close_flag_output(close_flag_output), .irq(irq));
   host_flag_monitor host (.mclk(mclk), .rst_n(rst_n), .flag(completion_flag_output),
      .rises(rises));

   task automatic chk(input logic [DW-1:0] seen, input logic [DW-1:0] exp);
      cmp_count++;
      if (seen !== exp) begin
         mismatches++;
         $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask
   task automatic chkf(input logic c, input logic l);
      chk({15'h0, completion_flag_output}, {15'h0, c});
      chk({15'h0, close_flag_output}, {15'h0, l});
   endtask
   task automatic wr_reg(input logic [AW-1:0] a, input logic [DW-1:0] d);
      @(posedge mclk);
      addr  <= a;
      wdata <= d;
      wr    <= 1'b1;
      @(posedge mclk);
      wr <= 1'b0;
      repeat (3) @(posedge mclk);
      #1;
   endtask
   task automatic rd_reg(input logic [AW-1:0] a, output logic [DW-1:0] d);
      @(posedge mclk);
      addr <= a;
      rd   <= 1'b1;
      @(posedge mclk);
      rd <= 1'b0;
      #1;
      d = rdata;
   endtask
   task automatic step(input logic signed [31:0] e, input logic signed [15:0] r, f);
      @(posedge mclk);
      following_error        <= e;
      raw_speed_command      <= r;
      filtered_speed_command <= f;
      repeat (3) @(posedge mclk);
      #1;
   endtask
   task automatic tick;
      @(posedge mclk);
      ms_tick <= 1'b1;
      @(posedge mclk);
      ms_tick <= 1'b0;
      repeat (3) @(posedge mclk);
      #1;
   endtask
   task automatic end_sim;
      $display("comparisons %0d mismatches %0d", cmp_count, mismatches);
      if (mismatches == 0 && cmp_count > 0) begin
         $display("ALL TESTS PASSED");
      end else begin
         $display("TESTS FAILED");
      end
      $finish;
   endtask

   // whole run is a few hundred cycles
   initial begin
      repeat (20000) @(posedge mclk);
      mismatches++;
      end_sim;
   end

   initial begin
      repeat (10) @(posedge mclk);
      rst_n <= 1'b1;
      for (int i = 0; i < 5; i++) begin
         rd_reg(i[3:0], v);
         chk(v, rst_tab[i]);
      end
      @(posedge mclk);
      #1;
      chk(rdata, 16'h0000);
      rd_reg(4'hf, v);
      chk(v, 16'h0000);
      $display("test reset values done");
      wr_reg(A_HOLD, 16'h0002);
      for (int s = 0; s < 4; s++) begin
         step(-32'sd5, 16'sh0, 16'sh0);
         wr_reg(A_CMP_SEL, 16'(s));
         wr_reg(A_CLS_SEL, 16'(s));
         wr_reg(A_CTRL, 16'h0003);
         tick;
         chkf(1'b0, 1'b0);
         tick;
         chkf(1'b1, 1'b1);
         step(-32'sd5, 16'sh0, 16'sh1);
         chkf(s != 2, s != 2);
         step(32'sd50, 16'sh0, 16'sh0);
         chkf(s == 3, s != 2);
         step(32'sd50, -16'sh1, 16'sh0);
         chkf(1'b0, s == 0);
         wr_reg(A_CTRL, 16'h0000);
         chkf(1'b0, 1'b0);
      end
      chk({8'h00, rises}, 16'h0004);
      $display("test selectors done");
      step(-32'sd5, 16'sh0, 16'sh0);
      wr_reg(A_CMP_SEL, 16'h0000);
      wr_reg(A_CLS_SEL, 16'h0000);
      wr_reg(A_CTRL, 16'h0003);
      tick;
      tick;
      chkf(1'b1, 1'b1);
      wr_reg(A_CMP_THR, 16'h0005);
      wr_reg(A_CLS_THR, 16'h0005);
      chkf(1'b0, 1'b0);
      wr_reg(A_CMP_THR, 16'h0006);
      tick;
      chkf(1'b0, 1'b0);
      tick;
      chkf(1'b1, 1'b0);
      $display("test thresholds done");
      chk({15'h0, irq}, 16'h0000);
      wr_reg(A_IRQ_EN, 16'h0001);
      chk({15'h0, irq}, 16'h0001);
      rd_reg(A_IRQ_STAT, v);
      chk(v, 16'h000f);
      wr_reg(A_IRQ_CLR, 16'h000f);
      rd_reg(A_IRQ_STAT, v);
      chk(v, 16'h0000);
      chk({15'h0, irq}, 16'h0000);
      wr_reg(A_CTRL, 16'h0000);
      chk({15'h0, irq}, 16'h0000);
      wr_reg(A_IRQ_EN, 16'h0002);
      chk({15'h0, irq}, 16'h0001);
      $display("test interrupts done");
      wr_reg(A_CTRL, 16'h0001);
      tick;
      tick;
      chkf(1'b0, 1'b0);
      wr_reg(A_CTRL, 16'h0002);
      tick;
      tick;
      chkf(1'b0, 1'b0);
      wr_reg(A_CTRL, 16'h0003);
      chkf(1'b0, 1'b0);
      tick;
      tick;
      chkf(1'b1, 1'b0);
      $display("test mode gating done");
      end_sim;
   end
endmodule
